// ### sfb_pkg.sv
`default_nettype none
package sfb_pkg;
   // Sensor register offsets on the link
   localparam logic [6:0] SFB_OFS_CEIL_LO    = 7'h19;
   localparam logic [6:0] SFB_OFS_CEIL_HI    = 7'h1A;
   localparam logic [6:0] SFB_OFS_FLOOR_LO   = 7'h1B;
   localparam logic [6:0] SFB_OFS_FLOOR_HI   = 7'h1C;
   localparam logic [6:0] SFB_OFS_SHUT_LO    = 7'h1D;
   localparam logic [6:0] SFB_OFS_SHUT_HI    = 7'h1E;
   // Reset values before and after firmware download
   localparam logic [7:0] SFB_RST_FLOOR_HI   = 8'h0D;
   localparam logic [7:0] SFB_FW_FLOOR_HI    = 8'h0E;
   localparam logic [7:0] SFB_RST_SHUT_LO    = 8'h8C;
   localparam logic [7:0] SFB_FW_SHUT_LO     = 8'h00;
   localparam logic [7:0] SFB_RST_SHUT_HI    = 8'h20;
   localparam logic [7:0] SFB_RST_FLOOR_LO   = 8'hAC;
   localparam logic [15:0] SFB_RST_CEIL      = 16'h2EE0;
   // Legal floor range
   localparam logic [15:0] SFB_FLOOR_MIN     = 16'h7E0E;
   // Settle time in frames after activation
   localparam logic [1:0] SFB_SETTLE_FRAMES  = 2'h2;
   // Controller register byte offsets
   localparam logic [4:0] SFB_AVS_CTRL       = 5'h00;
   localparam logic [4:0] SFB_AVS_FLOOR      = 5'h04;
   localparam logic [4:0] SFB_AVS_SHUT       = 5'h08;
   localparam logic [4:0] SFB_AVS_CEIL       = 5'h0C;
   localparam logic [4:0] SFB_AVS_STATUS     = 5'h10;
   localparam logic [4:0] SFB_AVS_READBACK   = 5'h14;
   // Field positions and link step counts
   localparam int SFB_CTRL_PROGRAM           = 0;
   localparam int SFB_CTRL_READBACK          = 1;
   localparam int SFB_ST_ACTIVE              = 0;
   localparam int SFB_ST_RANGE_ERR           = 1;
   localparam int SFB_ST_BOUND_ERR           = 2;
   localparam int SFB_ST_DEV_BUSY            = 3;
   localparam logic [2:0] SFB_WR_STEPS       = 3'h6;
   localparam logic [1:0] SFB_RD_STEPS       = 2'h3;
endpackage : sfb_pkg
`default_nettype wire

// ### sfb_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfb_link_if;
   logic [6:0] addr;
   logic [7:0] wrData;
   logic       write;
   logic       read;
   logic [7:0] rdData;
   logic       rdValid;
   logic       busy;
   modport dev (input addr, input wrData, input write, input read,
                output rdData, output rdValid, output busy);
   modport host (output addr, output wrData, output write, output read,
                 input rdData, input rdValid, input busy);
endinterface : sfb_link_if
`default_nettype wire

// ### sfb_sensor_end.sv
`timescale 1ns/1ps
`default_nettype none
module sfb_sensor_end
   import sfb_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   sfb_link_if.dev          link,
   input  wire logic        downloadDone,
   input  wire logic        autoGainEnable,
   input  wire logic [15:0] requestedShutter,
   input  wire logic [15:0] requestedPeriod,
   input  wire logic [15:0] periodCeiling,
   input  wire logic [7:0]  floorLowByte,
   output logic      [15:0] activeShutter,
   output logic      [15:0] activePeriod,
   output logic             frameTick,
   output logic             firmwareRunning
);

   function automatic logic [15:0] sfbMax(input logic [15:0] a, input logic [15:0] b);
      sfbMax = (a > b) ? a : b;
   endfunction : sfbMax

   function automatic logic [15:0] sfbMin(input logic [15:0] a, input logic [15:0] b);
      sfbMin = (a < b) ? a : b;
   endfunction : sfbMin

   // Staged and active bound bytes
   logic [7:0]  floorHiStage_ff;
   logic [7:0]  nxt_floorHiStage;
   logic [7:0]  shutLoStage_ff;
   logic [7:0]  nxt_shutLoStage;
   logic [7:0]  shutHiStage_ff;
   logic [7:0]  nxt_shutHiStage;
   logic [7:0]  floorHiAct_ff;
   logic [7:0]  nxt_floorHiAct;
   logic [7:0]  shutLoAct_ff;
   logic [7:0]  nxt_shutLoAct;
   logic [7:0]  shutHiAct_ff;
   logic [7:0]  nxt_shutHiAct;
   logic        fwRun_ff;
   logic        nxt_fwRun;
   // Link answer
   logic [7:0]  rdData_ff;
   logic [7:0]  nxt_rdData;
   logic        rdValid_ff;
   logic        nxt_rdValid;
   // Frame timing and settling
   logic [15:0] frameCnt_ff;
   logic [15:0] nxt_frameCnt;
   logic        tick_ff;
   logic        nxt_tick;
   logic        busy_ff;
   logic        nxt_busy;
   logic [1:0]  settleCnt_ff;
   logic [1:0]  nxt_settleCnt;
   // Exposure and period outputs
   logic [15:0] shutter_ff;
   logic [15:0] nxt_shutter;
   logic [15:0] period_ff;
   logic [15:0] nxt_period;
   logic [15:0] floorBound;
   logic [15:0] shutterBound;
   logic [15:0] lastCount;

   // Register bank
   always_comb
   begin
      nxt_floorHiStage = floorHiStage_ff;
      nxt_shutLoStage  = shutLoStage_ff;
      nxt_shutHiStage  = shutHiStage_ff;
      nxt_floorHiAct   = floorHiAct_ff;
      nxt_shutLoAct    = shutLoAct_ff;
      nxt_shutHiAct    = shutHiAct_ff;
      nxt_fwRun        = fwRun_ff;
      nxt_rdData       = rdData_ff;
      nxt_rdValid      = 1'b0;
      if (link.write)
      begin
         case (link.addr)
            SFB_OFS_FLOOR_HI: nxt_floorHiStage = link.wrData;
            SFB_OFS_SHUT_LO:  nxt_shutLoStage  = link.wrData;
            SFB_OFS_SHUT_HI:  nxt_shutHiStage  = link.wrData;
            SFB_OFS_CEIL_HI:
            begin
               // Whole staged set moves over together
               nxt_floorHiAct = floorHiStage_ff;
               nxt_shutLoAct  = shutLoStage_ff;
               nxt_shutHiAct  = shutHiStage_ff;
            end
            default:
            begin
               nxt_floorHiStage = floorHiStage_ff;
            end
         endcase
      end
      if (link.read)
      begin
         nxt_rdValid = 1'b1;
         case (link.addr)
            SFB_OFS_FLOOR_HI: nxt_rdData = floorHiStage_ff;
            SFB_OFS_SHUT_LO:  nxt_rdData = shutLoStage_ff;
            SFB_OFS_SHUT_HI:  nxt_rdData = shutHiStage_ff;
            default:          nxt_rdData = 8'h00;
         endcase
      end
      // Download success overrides same-cycle writes to the floor-high and shutter-low bytes
      if (downloadDone)
      begin
         nxt_fwRun        = 1'b1;
         nxt_floorHiStage = SFB_FW_FLOOR_HI;
         nxt_floorHiAct   = SFB_FW_FLOOR_HI;
         nxt_shutLoStage  = SFB_FW_SHUT_LO;
         nxt_shutLoAct    = SFB_FW_SHUT_LO;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         floorHiStage_ff <= SFB_RST_FLOOR_HI;
         shutLoStage_ff  <= SFB_RST_SHUT_LO;
         shutHiStage_ff  <= SFB_RST_SHUT_HI;
         floorHiAct_ff   <= SFB_RST_FLOOR_HI;
         shutLoAct_ff    <= SFB_RST_SHUT_LO;
         shutHiAct_ff    <= SFB_RST_SHUT_HI;
         fwRun_ff        <= 1'b0;
         rdData_ff       <= 8'h00;
         rdValid_ff      <= 1'b0;
      end
      else
      begin
         floorHiStage_ff <= nxt_floorHiStage;
         shutLoStage_ff  <= nxt_shutLoStage;
         shutHiStage_ff  <= nxt_shutHiStage;
         floorHiAct_ff   <= nxt_floorHiAct;
         shutLoAct_ff    <= nxt_shutLoAct;
         shutHiAct_ff    <= nxt_shutHiAct;
         fwRun_ff        <= nxt_fwRun;
         rdData_ff       <= nxt_rdData;
         rdValid_ff      <= nxt_rdValid;
      end
   end

   // Frame timing and exposure selection
   always_comb
   begin
      floorBound   = {floorHiAct_ff, floorLowByte};
      shutterBound = {shutHiAct_ff, shutLoAct_ff};
      // Zero period would stall the counter, treat as one cycle
      lastCount    = (period_ff == 16'h0000) ? 16'h0000 : period_ff - 16'h0001;
      nxt_tick     = (frameCnt_ff >= lastCount);
      nxt_frameCnt = nxt_tick ? 16'h0000 : frameCnt_ff + 16'h0001;
      if (autoGainEnable)
      begin
         nxt_shutter = sfbMin(requestedShutter, shutterBound);
      end
      else
      begin
         nxt_shutter = shutterBound;
      end
      // Period follows the shutter, then is clamped to the bounds
      nxt_period = sfbMax(requestedPeriod, shutter_ff);
      nxt_period = sfbMin(nxt_period, periodCeiling);
      nxt_period = sfbMax(nxt_period, floorBound);
      nxt_busy      = busy_ff;
      nxt_settleCnt = settleCnt_ff;
      if (link.write && (link.addr == SFB_OFS_CEIL_HI))
      begin
         nxt_busy      = 1'b1;
         nxt_settleCnt = 2'h0;
      end
      else if (busy_ff && tick_ff)
      begin
         nxt_settleCnt = settleCnt_ff + 2'h1;
         if (nxt_settleCnt == SFB_SETTLE_FRAMES)
         begin
            nxt_busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         frameCnt_ff  <= 16'h0000;
         tick_ff      <= 1'b0;
         busy_ff      <= 1'b0;
         settleCnt_ff <= 2'h0;
         shutter_ff   <= {SFB_RST_SHUT_HI, SFB_RST_SHUT_LO};
         period_ff    <= SFB_RST_CEIL;
      end
      else
      begin
         frameCnt_ff  <= nxt_frameCnt;
         tick_ff      <= nxt_tick;
         busy_ff      <= nxt_busy;
         settleCnt_ff <= nxt_settleCnt;
         shutter_ff   <= nxt_shutter;
         period_ff    <= nxt_period;
      end
   end

   assign link.rdData     = rdData_ff;
   assign link.rdValid    = rdValid_ff;
   assign link.busy       = busy_ff;
   assign activeShutter   = shutter_ff;
   assign activePeriod    = period_ff;
   assign frameTick       = tick_ff;
   assign firmwareRunning = fwRun_ff;

endmodule : sfb_sensor_end
`default_nettype wire

// ### sfb_controller_end.sv
`timescale 1ns/1ps
`default_nettype none
module sfb_controller_end
   import sfb_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [4:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWritedata,
   input  wire logic [3:0]  avsByteenable,
   output logic      [31:0] avsReaddata,
   output logic             avsWaitrequest,
   sfb_link_if.host         link
);

   typedef enum logic [2:0] {
      SfbIdle, SfbWaitFree, SfbWrite, SfbSettle, SfbRead, SfbReadWait
   } sfb_state_e;

   function automatic logic [15:0] sfbMerge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
      sfbMerge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction : sfbMerge

   sfb_state_e  state_ff, nxt_state;
   logic [2:0]  step_ff, nxt_step;
   logic [15:0] floor_ff, nxt_floor;
   logic [15:0] shut_ff, nxt_shut;
   logic [15:0] ceil_ff, nxt_ceil;
   logic [23:0] readback_ff, nxt_readback;
   logic        rangeErr_ff, nxt_rangeErr;
   logic        boundErr_ff, nxt_boundErr;
   logic        ack_ff, nxt_ack;
   logic [31:0] rdData_ff, nxt_rdData;
   logic        take;
   logic        isDefault;
   logic        badRange;
   logic        badBound;

   always_comb
   begin
      take         = avsWrite && ack_ff;
      nxt_ack      = (avsRead || avsWrite) && !ack_ff;
      nxt_rdData   = rdData_ff;
      nxt_state    = state_ff;
      nxt_step     = step_ff;
      nxt_floor    = floor_ff;
      nxt_shut     = shut_ff;
      nxt_ceil     = ceil_ff;
      nxt_readback = readback_ff;
      nxt_rangeErr = rangeErr_ff;
      nxt_boundErr = boundErr_ff;
      isDefault    = (floor_ff == {SFB_RST_FLOOR_HI, SFB_RST_FLOOR_LO})
                     && (shut_ff == {SFB_RST_SHUT_HI, SFB_RST_SHUT_LO})
                     && (ceil_ff == SFB_RST_CEIL);
      badRange     = floor_ff < SFB_FLOOR_MIN;
      badBound     = !isDefault
                     && ({1'b0, ceil_ff} < ({1'b0, floor_ff} + {1'b0, shut_ff}));
      if (avsRead && !ack_ff)
      begin
         case (avsAddress)
            SFB_AVS_FLOOR:    nxt_rdData = {16'h0000, floor_ff};
            SFB_AVS_SHUT:     nxt_rdData = {16'h0000, shut_ff};
            SFB_AVS_CEIL:     nxt_rdData = {16'h0000, ceil_ff};
            SFB_AVS_STATUS:   nxt_rdData = {28'h0000000, link.busy, boundErr_ff,
                                            rangeErr_ff, state_ff != SfbIdle};
            SFB_AVS_READBACK: nxt_rdData = {8'h00, readback_ff};
            default:          nxt_rdData = 32'h00000000;
         endcase
      end
      if (take)
      begin
         case (avsAddress)
            SFB_AVS_FLOOR: nxt_floor = sfbMerge(floor_ff, avsWritedata, avsByteenable);
            SFB_AVS_SHUT:  nxt_shut  = sfbMerge(shut_ff, avsWritedata, avsByteenable);
            SFB_AVS_CEIL:  nxt_ceil  = sfbMerge(ceil_ff, avsWritedata, avsByteenable);
            SFB_AVS_STATUS:
            begin
               if (avsByteenable[0] && avsWritedata[SFB_ST_RANGE_ERR])
               begin
                  nxt_rangeErr = 1'b0;
               end
               if (avsByteenable[0] && avsWritedata[SFB_ST_BOUND_ERR])
               begin
                  nxt_boundErr = 1'b0;
               end
            end
            default:
            begin
               nxt_floor = floor_ff;
            end
         endcase
      end
      case (state_ff)
         SfbIdle:
         begin
            nxt_step = 3'h0;
            // Commands arriving while a sequence runs are dropped
            if (take && (avsAddress == SFB_AVS_CTRL) && avsByteenable[0])
            begin
               if (avsWritedata[SFB_CTRL_PROGRAM])
               begin
                  // Set wins over a same-cycle clear
                  nxt_rangeErr = nxt_rangeErr || badRange;
                  nxt_boundErr = nxt_boundErr || badBound;
                  if (!badRange && !badBound)
                  begin
                     nxt_state = SfbWaitFree;
                  end
               end
               else if (avsWritedata[SFB_CTRL_READBACK])
               begin
                  nxt_state = SfbRead;
               end
            end
         end
         SfbWaitFree:
         begin
            if (!link.busy)
            begin
               nxt_state = SfbWrite;
            end
         end
         SfbWrite:
         begin
            nxt_step = step_ff + 3'h1;
            if (step_ff == SFB_WR_STEPS - 3'h1)
            begin
               nxt_state = SfbSettle;
            end
         end
         SfbSettle:
         begin
            if (!link.busy)
            begin
               nxt_state = SfbIdle;
            end
         end
         SfbRead:
         begin
            nxt_state = SfbReadWait;
         end
         SfbReadWait:
         begin
            if (link.rdValid)
            begin
               case (step_ff)
                  3'h0:    nxt_readback[15:8]  = link.rdData;
                  3'h1:    nxt_readback[7:0]   = link.rdData;
                  default: nxt_readback[23:16] = link.rdData;
               endcase
               nxt_step  = step_ff + 3'h1;
               nxt_state = (step_ff == {1'b0, SFB_RD_STEPS} - 3'h1) ? SfbIdle : SfbRead;
            end
         end
         default:
         begin
            nxt_state = SfbIdle;
         end
      endcase
   end

   // Link request decode from state and step
   always_comb
   begin
      link.write  = (state_ff == SfbWrite);
      link.read   = (state_ff == SfbRead);
      link.addr   = SFB_OFS_CEIL_HI;
      link.wrData = 8'h00;
      if (state_ff == SfbWrite)
      begin
         case (step_ff)
            3'h0:    {link.addr, link.wrData} = {SFB_OFS_FLOOR_LO, floor_ff[7:0]};
            3'h1:    {link.addr, link.wrData} = {SFB_OFS_FLOOR_HI, floor_ff[15:8]};
            3'h2:    {link.addr, link.wrData} = {SFB_OFS_SHUT_LO, shut_ff[7:0]};
            3'h3:    {link.addr, link.wrData} = {SFB_OFS_SHUT_HI, shut_ff[15:8]};
            3'h4:    {link.addr, link.wrData} = {SFB_OFS_CEIL_LO, ceil_ff[7:0]};
            default: {link.addr, link.wrData} = {SFB_OFS_CEIL_HI, ceil_ff[15:8]};
         endcase
      end
      else
      begin
         case (step_ff)
            3'h0:    link.addr = SFB_OFS_SHUT_HI;
            3'h1:    link.addr = SFB_OFS_SHUT_LO;
            default: link.addr = SFB_OFS_FLOOR_HI;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff    <= SfbIdle;
         step_ff     <= 3'h0;
         floor_ff    <= {SFB_RST_FLOOR_HI, SFB_RST_FLOOR_LO};
         shut_ff     <= {SFB_RST_SHUT_HI, SFB_RST_SHUT_LO};
         ceil_ff     <= SFB_RST_CEIL;
         readback_ff <= 24'h000000;
         rangeErr_ff <= 1'b0;
         boundErr_ff <= 1'b0;
         ack_ff      <= 1'b0;
         rdData_ff   <= 32'h00000000;
      end
      else
      begin
         state_ff    <= nxt_state;
         step_ff     <= nxt_step;
         floor_ff    <= nxt_floor;
         shut_ff     <= nxt_shut;
         ceil_ff     <= nxt_ceil;
         readback_ff <= nxt_readback;
         rangeErr_ff <= nxt_rangeErr;
         boundErr_ff <= nxt_boundErr;
         ack_ff      <= nxt_ack;
         rdData_ff   <= nxt_rdData;
      end
   end

   assign avsWaitrequest = (avsRead || avsWrite) && !ack_ff;
   assign avsReaddata    = rdData_ff;

endmodule : sfb_controller_end
`default_nettype wire

// ### sfb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sfb_monitor
   import sfb_pkg::*;
(
   input wire logic       clock,
   input wire logic       rstn,
   input wire logic [6:0] addr,
   input wire logic [7:0] wrData,
   input wire logic       write,
   input wire logic       read,
   input wire logic [7:0] rdData,
   input wire logic       rdValid,
   input wire logic       busy,
   input wire logic       downloadDone
);
   logic [7:0]  shadowFf [6];
   logic [7:0]  nxt_shadow [6];
   logic [5:0]  knownFf;
   logic [5:0]  nxt_known;
   logic [6:0]  lastRdFf;
   logic [6:0]  nxt_lastRd;
   logic [7:0]  rdExpFf;
   logic [7:0]  nxt_rdExp;
   logic        rdChkFf;
   logic        nxt_rdChk;
   logic [2:0]  idx;
   logic [16:0] floorPlusShut;
   assign idx = 3'(addr - SFB_OFS_CEIL_LO);
   assign floorPlusShut = {1'b0, shadowFf[3], shadowFf[2]} + {1'b0, shadowFf[5], shadowFf[4]};
   always_comb
   begin
      nxt_shadow = shadowFf;
      nxt_known  = knownFf;
      nxt_lastRd = read ? addr : lastRdFf;
      nxt_rdExp  = (idx < 3'h6) ? shadowFf[idx] : 8'h00;
      nxt_rdChk  = read && addr >= SFB_OFS_FLOOR_HI && addr <= SFB_OFS_SHUT_HI && knownFf[idx];
      if (write && addr >= SFB_OFS_CEIL_LO && addr <= SFB_OFS_SHUT_HI)
      begin
         nxt_shadow[idx] = wrData;
         nxt_known[idx]  = 1'b1;
      end
      // Download rewrites two staged bytes unseen on the link
      if (downloadDone)
         nxt_known[4:3] = 2'b00;
   end
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         shadowFf <= '{default: 8'h00};
         knownFf  <= '0;
         lastRdFf <= '0;
         rdExpFf  <= '0;
         rdChkFf  <= 1'b0;
      end
      else
      begin
         shadowFf <= nxt_shadow;
         knownFf  <= nxt_known;
         lastRdFf <= nxt_lastRd;
         rdExpFf  <= nxt_rdExp;
         rdChkFf  <= nxt_rdChk;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_wr(logic [6:0] a);
      write && addr == a;
   endsequence
   sequence s_tail;
      s_wr(SFB_OFS_FLOOR_HI) ##1 s_wr(SFB_OFS_SHUT_LO) ##1 s_wr(SFB_OFS_SHUT_HI)
         ##1 s_wr(SFB_OFS_CEIL_LO) ##1 s_wr(SFB_OFS_CEIL_HI);
   endsequence
   property p_order;
      s_wr(SFB_OFS_FLOOR_LO) |=> s_tail;
   endproperty
   property p_floorRange;
      s_wr(SFB_OFS_FLOOR_HI) |-> {wrData, shadowFf[2]} >= SFB_FLOOR_MIN;
   endproperty
   property p_boundSum;
      s_wr(SFB_OFS_CEIL_HI) |-> {1'b0, wrData, shadowFf[0]} >= floorPlusShut;
   endproperty
   property p_activate;
      s_wr(SFB_OFS_CEIL_HI) |=> busy;
   endproperty
   property p_quiet;
      write |-> !busy;
   endproperty
   // Two frames span thousands of cycles; eight is a floor only
   property p_busyHold;
      $rose(busy) |-> busy [*8];
   endproperty
   property p_readOrder;
      read && addr == SFB_OFS_SHUT_LO |-> lastRdFf == SFB_OFS_SHUT_HI;
   endproperty
   property p_readAnswer;
      read |=> rdValid && !read;
   endproperty
   property p_staged;
      rdChkFf |-> rdValid && rdData == rdExpFf;
   endproperty
   a_order: assert property (p_order) else $error("link write order broken");
   a_floorRange: assert property (p_floorRange) else $error("floor out of range");
   a_boundSum: assert property (p_boundSum) else $error("ceiling below sum");
   a_activate: assert property (p_activate) else $error("no busy after ceiling");
   a_quiet: assert property (p_quiet) else $error("write while busy");
   a_busyHold: assert property (p_busyHold) else $error("busy too short");
   a_readOrder: assert property (p_readOrder) else $error("lower read first");
   a_readAnswer: assert property (p_readAnswer) else $error("read not answered");
   a_staged: assert property (p_staged) else $error("staged value lost");
endmodule : sfb_monitor
`default_nettype wire

// ### frame_shutter_bound_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module frame_shutter_bound_regs_tb
   import sfb_pkg::*;
;
   typedef struct {logic [15:0] fl, sh, ce, rs, rp; logic ag; logic [15:0] xs, xp;} sfb_row_s;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic [4:0]  avsAddress = '0;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWritedata = '0;
   logic [31:0] avsReaddata;
   logic [31:0] rd;
   logic        avsWaitrequest;
   logic        downloadDone = 1'b0;
   logic        autoGainEnable = 1'b1;
   logic [15:0] requestedShutter = '0;
   logic [15:0] requestedPeriod = '0;
   logic [15:0] periodCeiling = 16'h2EE0;
   logic [7:0]  floorLowByte = 8'hAC;
   logic [15:0] activeShutter;
   logic [15:0] activePeriod;
   logic        frameTick;
   logic        firmwareRunning;
   int          n_fail = 0;
   int          check_count = 0;
   int          cyc;
   logic [4:0]  resAddr [6] = '{SFB_AVS_FLOOR, SFB_AVS_SHUT, SFB_AVS_CEIL, SFB_AVS_STATUS,
                                5'h18, SFB_AVS_CTRL};
   logic [31:0] resVal [6] = '{32'h0DAC, 32'h208C, 32'h2EE0, 32'h0, 32'h0, 32'h0};
   sfb_row_s    rows [3] = '{
      '{16'h7E0E, 16'h1000, 16'h9000, 16'h0500, 16'h8000, 1'b1, 16'h0500, 16'h8000},
      '{16'h8000, 16'h1000, 16'h9000, 16'h2000, 16'h0100, 1'b1, 16'h1000, 16'h8000},
      '{16'h8000, 16'h1234, 16'hA000, 16'h0010, 16'hF000, 1'b0, 16'h1234, 16'hA000}};
   logic [15:0] errFl [2] = '{16'h7E0D, 16'h8000};
   logic [15:0] errSh [2] = '{16'h0001, 16'h1001};
   logic [15:0] errCe [2] = '{16'hFFFF, 16'h9000};
   logic [31:0] errBit [2] = '{32'h2, 32'h4};
   sfb_link_if link ();
   sfb_sensor_end i_sfb_sensor_end (.clock, .rstn, .link, .downloadDone, .autoGainEnable,
      .requestedShutter, .requestedPeriod, .periodCeiling, .floorLowByte, .activeShutter,
      .activePeriod, .frameTick, .firmwareRunning);
   sfb_controller_end i_sfb_controller_end (.clock, .rstn, .avsAddress, .avsRead, .avsWrite,
      .avsWritedata, .avsByteenable(4'hF), .avsReaddata, .avsWaitrequest, .link);
   sfb_monitor i_sfb_monitor (.clock, .rstn, .addr(link.addr), .wrData(link.wrData),
      .write(link.write), .read(link.read), .rdData(link.rdData), .rdValid(link.rdValid),
      .busy(link.busy), .downloadDone);
   always #12.5 clock = ~clock;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   // Entered just after an edge; leaves one edge after release
   task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] d);
      avsAddress <= a;
      avsWritedata <= d;
      avsWrite <= wr;
      avsRead <= !wr;
      // Only the watchdog ends a wait that never gets its answer
      do
         @(posedge clock);
      while (avsWaitrequest !== 1'b0);
      rd = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge clock);
   endtask : avs
   task automatic idle_wait;
      do
         avs(1'b0, SFB_AVS_STATUS, '0);
      while (rd[SFB_ST_ACTIVE] !== 1'b0);
   endtask : idle_wait
   task automatic readback(input logic [31:0] exp);
      avs(1'b1, SFB_AVS_CTRL, 32'h2);
      idle_wait();
      avs(1'b0, SFB_AVS_READBACK, '0);
      chk(rd, exp);
   endtask : readback
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (4) @(posedge clock);
      // Outputs hold their reset values while reset is held
      chk({activeShutter, activePeriod}, 32'h208C_2EE0);
      rstn <= 1'b1;
      @(posedge clock);
      foreach (resAddr[i])
      begin
         avs(1'b0, resAddr[i], '0);
         chk(rd, resVal[i]);
      end
      readback(32'h000D_208C);
      foreach (rows[i])
      begin
         floorLowByte <= rows[i].fl[7:0];
         periodCeiling <= rows[i].ce;
         requestedShutter <= rows[i].rs;
         requestedPeriod <= rows[i].rp;
         autoGainEnable <= rows[i].ag;
         avs(1'b1, SFB_AVS_FLOOR, {16'h0, rows[i].fl});
         avs(1'b1, SFB_AVS_SHUT, {16'h0, rows[i].sh});
         avs(1'b1, SFB_AVS_CEIL, {16'h0, rows[i].ce});
         avs(1'b1, SFB_AVS_CTRL, 32'h1);
         do
            avs(1'b0, SFB_AVS_STATUS, '0);
         while (rd[SFB_ST_DEV_BUSY] !== 1'b1);
         repeat (3) @(posedge clock);
         chk({16'h0, activeShutter}, {16'h0, rows[i].xs});
         chk({16'h0, activePeriod}, {16'h0, rows[i].xp});
         // Mid-run reset cuts the two-frame settle short to keep the run brief
         if (i < 2)
         begin
            rstn <= 1'b0;
            repeat (2) @(posedge clock);
            chk({activeShutter, activePeriod}, 32'h208C_2EE0);
            rstn <= 1'b1;
            @(posedge clock);
         end
      end
      while (frameTick !== 1'b1)
         @(posedge clock);
      cyc = 0;
      do
      begin
         @(posedge clock);
         cyc++;
      end
      while (frameTick !== 1'b1 && cyc < 70000);
      chk(32'(cyc), {16'h0, rows[2].xp});
      idle_wait();
      for (int i = 0; i < 2; i++)
      begin
         avs(1'b1, SFB_AVS_FLOOR, {16'h0, errFl[i]});
         avs(1'b1, SFB_AVS_SHUT, {16'h0, errSh[i]});
         avs(1'b1, SFB_AVS_CEIL, {16'h0, errCe[i]});
         avs(1'b1, SFB_AVS_CTRL, 32'h1);
         avs(1'b0, SFB_AVS_STATUS, '0);
         chk(rd, errBit[i]);
         chk({16'h0, activeShutter}, 32'h1234);
         avs(1'b1, SFB_AVS_STATUS, errBit[i]);
         avs(1'b0, SFB_AVS_STATUS, '0);
         chk(rd, 32'h0);
      end
      downloadDone <= 1'b1;
      @(posedge clock);
      downloadDone <= 1'b0;
      repeat (2) @(posedge clock);
      chk({31'h0, firmwareRunning}, 32'h1);
      readback(32'h000E_1200);
      close_out();
   end
   initial
   begin
      // Longest leg is two frames of the last row
      repeat (100000) @(posedge clock);
      n_fail++;
      close_out();
   end
endmodule : frame_shutter_bound_regs_tb
`default_nettype wire
